/* hdl/loc_consts.vh */
// Constants for the logic output conditioning block.
`ifndef LOC_CONSTS_VH
`define LOC_CONSTS_VH
`define LOC_CLK_HZ          50000000
`define LOC_MS_CYCLES       (`LOC_CLK_HZ / 1000)
`define LOC_ON_DELAY_MAX    16'hEA60
`define LOC_HOLD_MAX        16'h270F
`define LOC_SEL_W           4
`define LOC_SEL_NONE        4'h0
`define LOC_SEL_NO_FAULT    4'h1
`define LOC_SEL_BRAKE       4'h2
`define LOC_SEL_OUT_CONT    4'h3
`define LOC_SEL_PRECHARGE   4'h4
`define LOC_SEL_LINE_CONT   4'h5
`define LOC_REG_ASSIGN      4'h0
`define LOC_REG_ON_DELAY    4'h1
`define LOC_REG_HOLD        4'h2
`define LOC_REG_POLARITY    4'h3
`define LOC_REG_CARD        4'h4
`define LOC_REG_STATE       4'h5
`define LOC_CH_POS          4
`define LOC_RST_ON_DELAY    16'h0000
`define LOC_RST_HOLD        16'h0000
`define LOC_RST_POLARITY    1'b0
`define LOC_RST_ASSIGN      4'h0
`endif

/* hdl/loc_logic_outputs.v */
// Delay, hold and polarity conditioning for logic output channels two to four.
`timescale 1ns/1ps
`include "loc_consts.vh"

module loc_logic_outputs #(
   parameter integer MS_CYCLES = `LOC_MS_CYCLES,
   parameter integer NSRC      = 16
) (
   input  wire             i_mclk,
   input  wire             i_rst,
   input  wire [NSRC-1:0]  i_sources,
   input  wire             i_brake_contactor_source,
   input  wire             i_output_contactor_source,
   input  wire             i_precharge_contactor_source,
   input  wire             i_line_contactor_source,
   input  wire             i_no_fault_source,
   input  wire             i_card_a,
   input  wire             i_card_b,
   input  wire [7:0]       i_addr,
   input  wire [15:0]      i_wdata,
   input  wire             i_wr,
   input  wire             i_rd,
   output reg  [15:0]      o_rdata,
   output reg              o_logic_out_ch2,
   output reg              o_logic_out_ch3,
   output reg              o_logic_out_ch4
);

   reg  [2:0]  card_a_sync;
   reg  [2:0]  card_b_sync;
   reg         card_a;
   reg         card_b;
   reg  [15:0] tick_cnt;
   reg         ms_tick;
   reg  [3:0]  asg [1:3];
   reg  [15:0] on_dly [1:3];
   reg  [15:0] hold [1:3];
   reg  [1:3]  polarity_negative;
   reg  [1:3]  cond_q;
   reg  [1:3]  state;
   reg  [15:0] ms_cnt [1:3];
   reg  [1:3]  cond;
   reg  [1:3]  locked;
   reg  [1:3]  on_forced;
   reg  [1:3]  hold_forced;
   reg  [1:3]  on_done;
   reg  [1:3]  hold_done;
   wire [1:0]  wr_ch;
   wire [3:0]  wr_reg;
   integer     c;

   // Address bits 5:4 pick the channel (bits 7:6 are ignored), the lower nibble the register.
   // Channel code zero is refused like an absent card, though card status still answers there.
   assign wr_ch  = i_addr[5:4];
   assign wr_reg = i_addr[3:0];

   // Card presence comes from pins, so it is filtered.
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         card_a_sync <= 3'h0;
         card_b_sync <= 3'h0;
         card_a      <= 1'b0;
         card_b      <= 1'b0;
      end else begin
         card_a_sync <= {card_a_sync[1:0], i_card_a};
         card_b_sync <= {card_b_sync[1:0], i_card_b};
         if (card_a_sync[2] == card_a_sync[1])
            card_a <= card_a_sync[2];
         if (card_b_sync[2] == card_b_sync[1])
            card_b <= card_b_sync[2];
      end
   end

   // One shared millisecond tick drives every channel timer.
   // Its phase is free running, so a timer cannot know how far the first tick is.
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         tick_cnt <= 16'h0000;
         ms_tick  <= 1'b0;
      end else if (tick_cnt == MS_CYCLES[15:0] - 16'h0001) begin
         tick_cnt <= 16'h0000;
         ms_tick  <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
         ms_tick  <= 1'b0;
      end
   end

   // Source selection per channel.
   always @* begin
      for (c = 1; c <= 3; c = c + 1) begin
         case (asg[c])
            `LOC_SEL_NONE:      cond[c] = 1'b0;
            `LOC_SEL_NO_FAULT:  cond[c] = i_no_fault_source;
            `LOC_SEL_BRAKE:     cond[c] = i_brake_contactor_source;
            `LOC_SEL_OUT_CONT:  cond[c] = i_output_contactor_source;
            `LOC_SEL_PRECHARGE: cond[c] = i_precharge_contactor_source;
            `LOC_SEL_LINE_CONT: cond[c] = i_line_contactor_source;
            default:            cond[c] = i_sources[asg[c]];
         endcase
         locked[c] = (asg[c] == `LOC_SEL_NO_FAULT) || (asg[c] == `LOC_SEL_BRAKE) ||
                     (asg[c] == `LOC_SEL_PRECHARGE) || (asg[c] == `LOC_SEL_LINE_CONT);
         on_forced[c]   = locked[c] || (asg[c] == `LOC_SEL_OUT_CONT);
         hold_forced[c] = locked[c];

         // A nonzero delay waits one tick beyond its count, since the first tick may
         // arrive at once; this keeps the configured time fully elapsed.
         on_done[c]   = on_forced[c] || (on_dly[c] == 16'h0000) || (ms_cnt[c] > on_dly[c]);
         hold_done[c] = hold_forced[c] || (hold[c] == 16'h0000) || (ms_cnt[c] > hold[c]);
      end
   end

   // Channel two is always reachable; three and four follow their option cards.
   // A refused access leaves every stored value as it was.
   function ch_ok;
      input [1:0] ch;
      begin
         ch_ok = (ch == 2'h1) || (ch == 2'h2 && card_a) || (ch == 2'h3 && card_b);
      end
   endfunction

   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         for (c = 1; c <= 3; c = c + 1) begin
            asg[c]               <= `LOC_RST_ASSIGN;
            on_dly[c]            <= `LOC_RST_ON_DELAY;
            hold[c]              <= `LOC_RST_HOLD;
            polarity_negative[c] <= `LOC_RST_POLARITY;
            cond_q[c]            <= 1'b0;
            state[c]             <= 1'b0;
            ms_cnt[c]            <= 16'h0000;
         end
         o_rdata <= 16'h0000;
      end else begin
         o_rdata <= 16'h0000;
         if (i_rd && wr_reg == `LOC_REG_CARD) begin
            // Card status answers at any channel code.
            o_rdata <= {14'h0000, card_b, card_a};
         end else if (i_rd && ch_ok(wr_ch)) begin
            case (wr_reg)
               `LOC_REG_ASSIGN:   o_rdata <= {12'h000, asg[wr_ch]};
               `LOC_REG_ON_DELAY: o_rdata <= on_dly[wr_ch];
               `LOC_REG_HOLD:     o_rdata <= hold[wr_ch];
               `LOC_REG_POLARITY: o_rdata <= {15'h0000, polarity_negative[wr_ch]};
               `LOC_REG_STATE:    o_rdata <= {13'h0000, state};
               default:           o_rdata <= 16'h0000;
            endcase
         end

         // Out of range delay values are dropped and the old value is kept.
         // Forced timings act in behaviour only, so stored values survive reassignment.
         if (i_wr && ch_ok(wr_ch)) begin
            case (wr_reg)
               `LOC_REG_ASSIGN: asg[wr_ch] <= i_wdata[3:0];
               `LOC_REG_ON_DELAY:
                  if (i_wdata <= `LOC_ON_DELAY_MAX)
                     on_dly[wr_ch] <= i_wdata;
               `LOC_REG_HOLD:
                  if (i_wdata <= `LOC_HOLD_MAX)
                     hold[wr_ch] <= i_wdata;
               `LOC_REG_POLARITY: polarity_negative[wr_ch] <= i_wdata[0];
               default: ;
            endcase
         end

         // Each channel timer runs only while the condition differs from the state.
         // Any change of the condition clears the count, so timing restarts from the
         // newest edge and a short glitch never completes a delay.
         for (c = 1; c <= 3; c = c + 1) begin
            cond_q[c] <= cond[c];
            if (cond[c] != cond_q[c])
               ms_cnt[c] <= 16'h0000;
            else if (cond[c] == state[c])
               ms_cnt[c] <= 16'h0000;
            else if (cond[c]) begin
               if (on_done[c])
                  state[c] <= 1'b1;
               else if (ms_tick)
                  ms_cnt[c] <= ms_cnt[c] + 16'h0001;
            end else begin
               if (hold_done[c])
                  state[c] <= 1'b0;
               else if (ms_tick)
                  ms_cnt[c] <= ms_cnt[c] + 16'h0001;
            end
         end
      end
   end


   // Pin levels are registered so the outputs never glitch on selector changes.
   // Without its card a channel's pin stays low whatever its polarity.
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_logic_out_ch2 <= 1'b0;
         o_logic_out_ch3 <= 1'b0;
         o_logic_out_ch4 <= 1'b0;
      end else begin
         o_logic_out_ch2 <= state[1] ^ (polarity_negative[1] & ~locked[1]);
         o_logic_out_ch3 <= (state[2] ^ (polarity_negative[2] & ~locked[2])) & card_a;
         o_logic_out_ch4 <= (state[3] ^ (polarity_negative[3] & ~locked[3])) & card_b;
      end
   end

endmodule

/* tb/loc_sva.sv */
// Checker for the logic output conditioning block.
`timescale 1ns/1ps
module loc_sva (
   input wire        i_mclk,
   input wire        i_rst,
   input wire        i_brake_contactor_source,
   input wire        i_no_fault_source,
   input wire        i_card_a,
   input wire [7:0]  i_addr,
   input wire [15:0] i_wdata,
   input wire        i_wr,
   input wire        i_rd,
   input wire [15:0] o_rdata,
   input wire        o_logic_out_ch2,
   input wire        o_logic_out_ch3
);
   reg  [3:0] sel;
   reg        neg;
   wire       brk = i_brake_contactor_source;
   wire       nf  = i_no_fault_source;
   wire       out = o_logic_out_ch2;
   // Mirrors the second channel's assignment and polarity as written.
   always @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sel <= 4'h0;
         neg <= 1'b0;
      end else if (i_wr) begin
         if (i_addr == 8'h10) sel <= i_wdata[3:0];
         if (i_addr == 8'h13) neg <= i_wdata[0];
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data not idle");
   brake_on_a: assert property ((sel == 4'h2 && brk)[*5] |-> out)
      else $error("brake output late");
   brake_off_a: assert property ((sel == 4'h2 && !brk)[*5] |-> !out)
      else $error("brake output held");
   fault_on_a: assert property ((sel == 4'h1 && nf)[*5] |-> out)
      else $error("fault output not positive");
   fault_off_a: assert property ((sel == 4'h1 && !nf)[*5] |-> !out)
      else $error("fault output held");
   none_lvl_a: assert property ((sel == 4'h0 && $stable(neg))[*5] |-> out == neg)
      else $error("idle level wrong");
   card_gate_a: assert property ((!i_card_a)[*8] |-> !o_logic_out_ch3)
      else $error("third channel active without card");
   card_read_a: assert property (($stable(i_card_a)[*6] ##0 i_rd && i_addr[3:0] == 4'h4)
      |=> o_rdata[0] == $past(i_card_a)) else $error("card status wrong");
   cover property (sel == 4'h2 && out);
   cover property (o_logic_out_ch3);
   cover property (i_rd && i_addr[3:0] == 4'h4);
endmodule
bind loc_logic_outputs loc_sva u_sva (.*);

/* tb/loc_load.sv */
// Load model: coils that pick up one clock after the outputs drive them.
`timescale 1ns/1ps
module loc_load (
   input  wire       i_mclk,
   input  wire [2:0] i_drive,
   output reg  [2:0] o_energized
);
   always @(posedge i_mclk) o_energized <= i_drive;
endmodule

/* tb/loc_logic_outputs_tb_top.sv */
// Self-checking bench for the logic output conditioning block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module loc_logic_outputs_tb_top;
   reg         i_mclk = 0, i_rst = 1, i_wr = 0, i_rd = 0, ca = 0, cb = 0;
   reg  [7:0]  i_addr = 8'h00;
   reg  [15:0] i_wdata = 16'h0000, src = 16'h0000;
   reg  [4:0]  sv = 5'h00;
   wire [15:0] rdata;
   wire [2:0]  outs, coil;
   integer     bad_count = 0, checked = 0, i;
   always #10 i_mclk = ~i_mclk;
   loc_logic_outputs #(.MS_CYCLES(10)) u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_sources(src),
      .i_no_fault_source(sv[0]), .i_brake_contactor_source(sv[1]),
      .i_output_contactor_source(sv[2]), .i_precharge_contactor_source(sv[3]),
      .i_line_contactor_source(sv[4]), .i_card_a(ca), .i_card_b(cb), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
      .o_logic_out_ch2(outs[0]), .o_logic_out_ch3(outs[1]), .o_logic_out_ch4(outs[2]));
   loc_load u_load (.i_mclk(i_mclk), .i_drive(outs), .o_energized(coil));
   task cy(input integer n);
      begin repeat (n) @(posedge i_mclk); #1; end
   endtask
   task wr(input [7:0] a, input [15:0] d);
      begin i_addr <= a; i_wdata <= d; i_wr <= 1; cy(1); i_wr <= 0; cy(1); end
   endtask
   task rd(input [7:0] a, input [15:0] e);
      begin i_addr <= a; i_rd <= 1; cy(1); i_rd <= 0; `CHK("rdata", e, rdata) cy(1); end
   endtask
   task wt(input integer k, input e, input integer n);
      begin i = 0; while (outs[k] !== e && i < n) begin cy(1); i++; end
         `CHK("output", e, outs[k]) end
   endtask
   task t_defaults;
      begin rd(8'h10, 0); rd(8'h11, 0); rd(8'h12, 0); rd(8'h13, 0); rd(8'h1F, 0); end
   endtask
   task t_delays;
      begin wr(8'h10, 16'h0006); wr(8'h11, 16'h0003); wr(8'h12, 16'h0002);
         wr(8'h11, 16'hEA61); rd(8'h11, 16'h0003); wr(8'h12, 16'h2710); rd(8'h12, 16'h0002);
         src[6] <= 1; cy(15); src[6] <= 0; cy(5); src[6] <= 1; cy(27);
         `CHK("on delay", 1'b0, outs[0]) wt(0, 1, 25);
         src[6] <= 0; cy(17); `CHK("hold", 1'b1, outs[0]) wt(0, 0, 25); end
   endtask
   task t_pol;
      begin wr(8'h11, 0); wr(8'h12, 0); wr(8'h13, 1); wt(0, 1, 5);
         src[6] <= 1; wt(0, 0, 5); src[6] <= 0; wt(0, 1, 5); end
   endtask
   task t_locked;
      integer c;
      begin wr(8'h11, 16'h0005); wr(8'h12, 16'h0002); wr(8'h13, 16'h0001);
         for (c = 1; c <= 5; c++) begin
            wr(8'h10, c[15:0]); sv[c-1] <= 1; cy(5); `CHK("forced on", c != 3, outs[0])
            sv[c-1] <= 0; cy(5); `CHK("forced off", 1'b0, outs[0])
            if (c == 3) wt(0, 1, 40);
         end
      end
   endtask
   task t_cards;
      begin wr(8'h20, 16'h0006); ca <= 1; cy(6); rd(8'h24, 16'h0001);
         rd(8'h14, 16'h0001);
         rd(8'h20, 16'h0000); src[6] <= 1; cy(5); `CHK("ch3 off", 1'b0, outs[1])
         wr(8'h20, 16'h0006); wt(1, 1, 6); cy(1); `CHK("coil", 1'b1, coil[1])
         wr(8'h30, 16'h0002); sv[1] <= 1; cy(6); `CHK("ch4 off", 1'b0, outs[2])
         cb <= 1; cy(6); wr(8'h30, 16'h0002); wt(2, 1, 6); end
   endtask
   task complete_run;
      begin
         if (bad_count == 0 && checked > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      cy(12); i_rst <= 0; cy(2);
      t_defaults; t_delays; t_pol; t_locked; t_cards;
      complete_run;
   end
   initial begin cy(5000); bad_count++; complete_run; end
endmodule
